// ===== core/refclk_lock_irq.sv
// Reference-assisted lock, lock pins, reference pass-through and eye interrupt.
`timescale 1ns/10ps
`include "refclk_lock_regs.svh"

module refclk_lock_irq #(
   parameter int NCH    = 4,
   parameter int CNT_W  = 16,
   parameter int TUNE_W = 8
) (
   input  wire logic                       pclk,      // 100 MHz clock
   input  wire logic                       presetn,   // Async reset, low
   input  wire logic                       psel,      // APB select
   input  wire logic                       penable,   // APB enable
   input  wire logic                       pwrite,    // APB direction
   input  wire logic [7:0]                 paddr,     // APB byte address
   input  wire logic [31:0]                pwdata,    // APB write data
   output logic      [31:0]                prdata,    // APB read data
   output logic                            pready,    // APB ready
   output logic                            pslverr,   // APB error
   input  wire logic                       reference_clock_input,  // Pin
   output logic                            reference_clock_output, // Pin
   input  wire logic [NCH-1:0]             vco_div_clk,  // Divided VCO
   input  wire logic [NCH-1:0]             phase_ok,     // Analog detector
   input  wire refclk_lock_pkg::eye_meas_t eye_meas [NCH], // Measurement
   input  wire logic [NCH-1:0]             eye_valid,    // Measurement done
   output logic [NCH-1:0][TUNE_W-1:0]      coarse_tune,  // VCO coarse code
   output logic [NCH-1:0]                  cdr_in_reset, // CDR held reset
   output logic [NCH-1:0]                  data_clk_vco, // Retime clock sel
   input  wire logic [NCH-1:0]             lock_pin_in,  // Lock pin level
   output refclk_lock_pkg::pin_drive_t [NCH-1:0] lock_pin, // Lock drive
   output refclk_lock_pkg::pin_drive_t     int_pin       // Interrupt drive
);
   import refclk_lock_pkg::*;

   localparam int STRAP_CYC =
      (`STRAP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WIN_W = $clog2(`WIN_REF_EDGES + 1);

   initial begin
      if (NCH < 1 || NCH > 4 || CNT_W < 8 || CNT_W > 16 ||
          TUNE_W < 2 || TUNE_W > 8) begin
         $error("refclk_lock_irq: unsupported parameters");
      end
   end

   function automatic logic in_tol(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] exp,
                                   input logic [7:0]       tol);
      logic [CNT_W:0] diff;
      diff = (cnt > exp) ? {1'b0, cnt - exp} : {1'b0, exp - cnt};
      return diff <= {{(CNT_W-7){1'b0}}, tol};
   endfunction : in_tol

   // Register state.
   logic [1:0]       ref_mode;
   logic             fld_dis;
   logic [NCH-1:0]   cdr_ovr;
   logic [NCH-1:0]   cdr_force;
   logic [CNT_W-1:0] exp_cnt;
   logic [7:0]       tol;
   logic [7:0]       heo_thr;
   logic [7:0]       veo_thr;
   logic [NCH-1:0]   eye_en;
   logic [7:0]       status;
   logic [7:0]       mask;
   logic [TUNE_W-1:0] preset;
   eye_cap_t         cap;
   logic             cap_valid;
   logic [NCH-1:0]   locked;
   logic [NCH-1:0]   strap;
   logic             strap_done;

   logic wr_acc;
   logic rd_setup;
   logic rd_acc;
   logic mapped;
   logic [31:0] rd_mux;
   logic [7:0]  rd_clear;
   logic        cap_read;
   logic [NCH-1:0] eye_evt;
   logic [NCH-1:0] loss_evt;

   assign wr_acc   = psel & penable & pwrite;
   assign rd_acc   = psel & penable & ~pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `OFS_CTRL: begin
            rd_mux[`CTRL_REF_LSB +: 2] = ref_mode;
            rd_mux[`CTRL_FLD_BIT]      = fld_dis;
         end
         `OFS_CDR_RESET: begin
            rd_mux[`OVR_LSB +: NCH] = cdr_ovr;
            rd_mux[NCH-1:0]         = cdr_force;
         end
         `OFS_FREQ: begin
            rd_mux[`FREQ_EXP_LSB +: CNT_W] = exp_cnt;
            rd_mux[`FREQ_TOL_LSB +: 8]     = tol;
         end
         `OFS_EYE_THR: begin
            rd_mux[7:0]                = heo_thr;
            rd_mux[`THR_VEO_LSB +: 8]  = veo_thr;
         end
         `OFS_EYE_EN:  rd_mux[NCH-1:0]    = eye_en;
         `OFS_STATUS:  rd_mux[7:0]        = status;
         `OFS_MASK:    rd_mux[7:0]        = mask;
         `OFS_PRESET:  rd_mux[TUNE_W-1:0] = preset;
         `OFS_CAPTURE: begin
            rd_mux[`CAP_HEO_LSB +: 8] = cap.eye.horizontal_eye_opening;
            rd_mux[`CAP_VEO_LSB +: 8] = cap.eye.vertical_eye_opening;
            rd_mux[`CAP_CH_LSB +: 2]  = cap.channel;
            rd_mux[`CAP_VALID_BIT]    = cap_valid;
         end
         `OFS_LOCK_STAT: begin
            rd_mux[NCH-1:0]                = locked;
            rd_mux[`LOCK_STRAP_LSB +: NCH] = strap;
         end
         default: mapped = 1'b0;
      endcase
   end

   // Slave answers in the first access cycle; read data was latched at setup.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // Only bits that were actually returned are cleared, so new events survive.
   assign rd_clear = (rd_acc && paddr == `OFS_STATUS) ? prdata[7:0] : 8'h00;
   assign cap_read = rd_acc && paddr == `OFS_CAPTURE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_mode  <= `REF_MODE_RST;
         fld_dis   <= `FLD_DIS_RST;
         cdr_ovr   <= '0;
         cdr_force <= '0;
         exp_cnt   <= CNT_W'(`FREQ_RST);
         tol       <= 8'(`FREQ_RST >> `FREQ_TOL_LSB);
         heo_thr   <= 8'(`THR_RST);
         veo_thr   <= 8'(`THR_RST >> `THR_VEO_LSB);
         eye_en    <= '0;
         mask      <= 8'h00;
         preset    <= TUNE_W'(`PRESET_RST);
      end else if (wr_acc) begin
         case (paddr)
            `OFS_CTRL: begin
               ref_mode <= pwdata[`CTRL_REF_LSB +: 2];
               fld_dis  <= pwdata[`CTRL_FLD_BIT];
            end
            `OFS_CDR_RESET: begin
               cdr_ovr   <= pwdata[`OVR_LSB +: NCH];
               cdr_force <= pwdata[NCH-1:0];
            end
            `OFS_FREQ: begin
               exp_cnt <= pwdata[`FREQ_EXP_LSB +: CNT_W];
               tol     <= pwdata[`FREQ_TOL_LSB +: 8];
            end
            `OFS_EYE_THR: begin
               heo_thr <= pwdata[7:0];
               veo_thr <= pwdata[`THR_VEO_LSB +: 8];
            end
            `OFS_EYE_EN: eye_en <= pwdata[NCH-1:0];
            `OFS_MASK:   mask   <= pwdata[7:0];
            `OFS_PRESET: preset <= pwdata[TUNE_W-1:0];
            default: ;
         endcase
      end
   end

   // Reference input: synchronised, then edge-detected past the second stage.
   logic ref_s1;
   logic ref_s2;
   logic ref_s3;
   logic ref_edge;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
      end else begin
         ref_s1 <= reference_clock_input;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
      end
   end
   assign ref_edge = ref_s2 & ~ref_s3;

   // A sampled copy only: good for daisy-chaining, but it carries the
   // sampling jitter of one pclk period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_clock_output <= 1'b0;
      end else begin
         reference_clock_output <= ref_s2;
      end
   end

   // Strap capture on the shared lock pins after reset release.
   logic [NCH-1:0] lk_s1;
   logic [NCH-1:0] lk_s2;
   logic [$clog2(STRAP_CYC+1)-1:0] strap_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_s1 <= '0;
         lk_s2 <= '0;
      end else begin
         lk_s1 <= lock_pin_in;
         lk_s2 <= lk_s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt  <= '0;
         strap_done <= 1'b0;
         strap      <= '0;
      end else if (!strap_done) begin
         if (strap_cnt == STRAP_CYC[$bits(strap_cnt)-1:0]) begin
            strap      <= lk_s2;
            strap_done <= 1'b1;
         end else begin
            strap_cnt <= strap_cnt + 1'b1;
         end
      end
   end

   // Per-channel acquisition.
   logic assist;
   assign assist = (ref_mode == `REF_MODE_ASSIST);

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         chan_state_t      st;
         logic [WIN_W-1:0] win;
         logic [CNT_W-1:0] vcnt;
         logic [CNT_W-1:0] vlast;
         logic             win_end;
         logic             v_s1;
         logic             v_s2;
         logic             v_s3;
         logic             p_s1;
         logic             p_s2;
         logic             freq_ok;
         logic             rst_req;

         assign rst_req = cdr_ovr[c] & cdr_force[c];
         assign win_end = ref_edge &&
                          win == WIN_W'(`WIN_REF_EDGES - 1);
         assign freq_ok = in_tol(vcnt, exp_cnt, tol);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               v_s1 <= 1'b0;
               v_s2 <= 1'b0;
               v_s3 <= 1'b0;
               p_s1 <= 1'b0;
               p_s2 <= 1'b0;
            end else begin
               v_s1 <= vco_div_clk[c];
               v_s2 <= v_s1;
               v_s3 <= v_s2;
               p_s1 <= phase_ok[c];
               p_s2 <= p_s1;
            end
         end

         // VCO edges counted over a window of reference edges.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               win   <= '0;
               vcnt  <= '0;
               vlast <= '0;
            end else if (st == ST_RESET) begin
               win   <= '0;
               vcnt  <= '0;
            end else begin
               if (ref_edge) begin
                  win <= win_end ? '0 : win + 1'b1;
               end
               if (win_end) begin
                  vlast <= vcnt;
                  vcnt  <= '0;
               end else if (v_s2 & ~v_s3) begin
                  vcnt <= vcnt + 1'b1;
               end
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st             <= ST_RESET;
               coarse_tune[c] <= '0;
               loss_evt[c]    <= 1'b0;
            end else begin
               loss_evt[c] <= 1'b0;
               if (rst_req) begin
                  st <= ST_RESET;
               end else begin
                  case (st)
                     ST_RESET:  st <= ST_PRESET;
                     ST_PRESET: begin
                        coarse_tune[c] <= preset;
                        st <= assist ? ST_CAL : ST_ACQ;
                     end
                     ST_CAL: if (win_end) begin
                        // Coarse tuning only; data timing never sees ref.
                        if (freq_ok) begin
                           st <= ST_ACQ;
                        end else if (vcnt < exp_cnt) begin
                           coarse_tune[c] <= coarse_tune[c] + 1'b1;
                        end else begin
                           coarse_tune[c] <= coarse_tune[c] - 1'b1;
                        end
                     end
                     ST_ACQ: begin
                        if (!assist && p_s2) begin
                           st <= ST_LOCKED;
                        end else if (win_end && p_s2 &&
                                     (fld_dis || freq_ok)) begin
                           st <= ST_LOCKED;
                        end
                     end
                     ST_LOCKED: begin
                        if (!p_s2 || (win_end && !fld_dis && !freq_ok))
                        begin
                           st          <= ST_ACQ;
                           loss_evt[c] <= 1'b1;
                        end
                     end
                     default: st <= ST_RESET;
                  endcase
               end
            end
         end

         assign locked[c]       = (st == ST_LOCKED);
         assign cdr_in_reset[c] = (st == ST_RESET);
         assign data_clk_vco[c] = 1'b1;

         assign eye_evt[c] = eye_valid[c] & eye_en[c] &
            (eye_meas[c].horizontal_eye_opening < heo_thr ||
             eye_meas[c].vertical_eye_opening < veo_thr);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lock_pin[c] <= '{oe_n: 1'b1, out: 1'b0};
            end else begin
               lock_pin[c].oe_n <= ~strap_done;
               lock_pin[c].out  <= locked[c] & strap_done;
            end
         end
      end
   endgenerate

   // Sticky status, read-to-clear; a set in the read cycle wins.
   logic [7:0] set_bits;
   always_comb begin
      set_bits = 8'h00;
      set_bits[`STAT_EYE_LSB +: NCH]  = eye_evt;
      set_bits[`STAT_LOSS_LSB +: NCH] = loss_evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 8'h00;
      end else begin
         status <= (status & ~rd_clear) | set_bits;
      end
   end

   // First eye event is held until its register is read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap       <= '0;
         cap_valid <= 1'b0;
      end else if ((!cap_valid || cap_read) && |eye_evt) begin
         for (int i = NCH - 1; i >= 0; i--) begin
            if (eye_evt[i]) begin
               cap.channel <= 2'(i);
               cap.eye     <= eye_meas[i];
            end
         end
         cap_valid <= 1'b1;
      end else if (cap_read) begin
         cap_valid <= 1'b0;
      end
   end

   // Open drain: only ever pulls low, so lines can be wired together.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_pin <= '{oe_n: 1'b1, out: 1'b0};
      end else begin
         int_pin.oe_n <= ~|(status & mask);
         int_pin.out  <= 1'b0;
      end
   end

endmodule : refclk_lock_irq

// ===== common/refclk_lock_regs.svh
// Register offsets, field positions, reset values and timing for the block.
`ifndef REFCLK_LOCK_REGS_SVH
`define REFCLK_LOCK_REGS_SVH

`define OFS_CTRL        8'h00
`define OFS_CDR_RESET   8'h04
`define OFS_FREQ        8'h08
`define OFS_EYE_THR     8'h0C
`define OFS_EYE_EN      8'h10
`define OFS_STATUS      8'h14
`define OFS_MASK        8'h18
`define OFS_CAPTURE     8'h1C
`define OFS_LOCK_STAT   8'h20
`define OFS_PRESET      8'h24

`define CTRL_REF_LSB    4
`define CTRL_FLD_BIT    1
`define REF_MODE_RST    2'h3
`define REF_MODE_ASSIST 2'h3
`define FLD_DIS_RST     1'h1

`define FREQ_EXP_LSB    0
`define FREQ_TOL_LSB    16
`define FREQ_RST        32'h00FF_3390
`define THR_VEO_LSB     8
`define THR_RST         16'h2020
`define PRESET_RST      8'h80
`define OVR_LSB         4

`define STAT_EYE_LSB    0
`define STAT_LOSS_LSB   4
`define CAP_HEO_LSB     0
`define CAP_VEO_LSB     8
`define CAP_CH_LSB      16
`define CAP_VALID_BIT   31
`define LOCK_STRAP_LSB  4

`define CLK_PERIOD_NS   10
`define STRAP_HOLD_NS   200
`define WIN_REF_EDGES   32

`endif

// ===== common/refclk_lock_pkg.sv
// Types shared by the reference-clock, lock and interrupt block.
package refclk_lock_pkg;

   typedef enum logic [2:0] {
      ST_RESET  = 3'h0,
      ST_PRESET = 3'h1,
      ST_CAL    = 3'h3,
      ST_ACQ    = 3'h2,
      ST_LOCKED = 3'h6
   } chan_state_t;

   typedef struct packed {
      logic [7:0] horizontal_eye_opening;
      logic [7:0] vertical_eye_opening;
   } eye_meas_t;

   typedef struct packed {
      logic [1:0] channel;
      eye_meas_t  eye;
   } eye_cap_t;

   typedef struct packed {
      logic       oe_n;
      logic       out;
   } pin_drive_t;

endpackage : refclk_lock_pkg

// ===== testbench/refclk_lock_irq_assertions.sv
// Port-level assertions for the reference, lock and interrupt block.
`timescale 1ns/10ps
module refclk_lock_irq_assertions #(
   parameter int NCH = 4
) (
   input wire logic                                 pclk,     // Clock
   input wire logic                                 presetn,  // Reset
   input wire logic                                 psel,     // Select
   input wire logic                                 penable,  // Enable
   input wire logic                                 pwrite,   // Write
   input wire logic [7:0]                           paddr,    // Address
   input wire logic [31:0]                          pwdata,   // Data
   input wire logic                                 pslverr,  // Error
   input wire logic                                 reference_clock_input,
   input wire logic                                 reference_clock_output,
   input wire logic [NCH-1:0]                       phase_ok, // Phase
   input wire logic [NCH-1:0]                       cdr_in_reset, // CDR
   input wire logic [NCH-1:0]                       data_clk_vco, // Sel
   input wire refclk_lock_pkg::pin_drive_t [NCH-1:0] lock_pin, // Lock
   input wire refclk_lock_pkg::pin_drive_t          int_pin   // Int
);
   import refclk_lock_pkg::*;
   logic [NCH-1:0] lk_out;
   logic [NCH-1:0] lk_oen;
   logic [4:0]     rel_cyc;
   logic [3:0]     cdr_req;
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         lk_out[c] = lock_pin[c].out;
         lk_oen[c] = lock_pin[c].oe_n;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_cyc <= 5'h00;
      end else if (rel_cyc != 5'h1F) begin
         rel_cyc <= rel_cyc + 5'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cdr_req <= 4'h0;
      end else if (psel && penable && pwrite && paddr == 8'h04) begin
         cdr_req <= pwdata[7:4] & pwdata[3:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence seq_cdr_held;
      (cdr_req != 4'h0) [*3];
   endsequence
   sequence seq_phase_lost;
      (!phase_ok[1]) [*6];
   endsequence
   AST_RETIME_VCO: assert property (data_clk_vco == '1)
      else $error("retime clock not taken from the VCO");
   AST_REF_COPY: assert property (
      $rose(reference_clock_input) |-> ##[1:5] $rose(reference_clock_output))
      else $error("reference output does not follow input");
   AST_INT_OPEN_DRAIN: assert property (int_pin.out == 1'b0)
      else $error("interrupt pad drives high");
   AST_INT_IDLE: assert property (rel_cyc <= 5'h03 |-> int_pin.oe_n)
      else $error("interrupt asserted straight after reset");
   AST_STRAP_FREE: assert property (rel_cyc <= 5'h14 |-> &lk_oen)
      else $error("lock pad driven during strap sampling");
   AST_STRAP_DONE: assert property (rel_cyc == 5'h1A |-> lk_oen == '0)
      else $error("lock pad not driven after straps");
   AST_LOCK_DRIVEN: assert property ((lk_out & lk_oen) == '0)
      else $error("lock high while pad released");
   AST_CDR_LOW: assert property (
      seq_cdr_held |-> (cdr_in_reset & cdr_req) == cdr_req ##0
      (lk_out & cdr_req) == 4'h0)
      else $error("lock high while CDR held in reset");
   AST_LOSS_LOW: assert property (seq_phase_lost |-> !lk_out[1])
      else $error("lock high without phase lock");
   AST_SLVERR: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
      else $error("no error on unmapped address");
endmodule : refclk_lock_irq_assertions

bind refclk_lock_irq refclk_lock_irq_assertions #(.NCH(NCH)) u_asrt (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .reference_clock_input, .reference_clock_output, .phase_ok,
   .cdr_in_reset, .data_clk_vco, .lock_pin, .int_pin
);

// ===== testbench/chan_far_model.sv
// Far side: reference oscillator, divided VCO clocks and lock pads.
`timescale 1ns/10ps
module chan_far_model #(
   parameter int NCH = 4
) (
   input  wire logic [NCH-1:0]                       strap_val, // Straps
   input  wire refclk_lock_pkg::pin_drive_t [NCH-1:0] lock_pin, // Drive
   output logic                                      reference_clock_input,
   output logic [NCH-1:0]                            vco_div_clk, // VCO
   output logic [NCH-1:0]                            lock_pin_in  // Pads
);
   import refclk_lock_pkg::*;
   // The oscillator never stops, whatever mode the block is in.
   initial begin
      reference_clock_input = 1'b0;
      #7;
      forever #20 reference_clock_input = ~reference_clock_input;
   end
   // Edges sit off the bench clock edges so the synchronisers never tie.
   initial begin
      vco_div_clk = '0;
      #2.5;
      forever #10 vco_div_clk = ~vco_div_clk;
   end
   // A released pad settles to its strap resistor level.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         lock_pin_in[c] = lock_pin[c].oe_n ? strap_val[c] : lock_pin[c].out;
      end
   end
endmodule : chan_far_model

// ===== testbench/retimer_refclk_lock_interrupt_tb_top.sv
// Self-checking bench for the reference, lock and interrupt block.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("wrong value %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module retimer_refclk_lock_interrupt_tb_top;
   import refclk_lock_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic             reference_clock_input, reference_clock_output;
   logic [3:0]       vco_div_clk, phase_ok, eye_valid, cdr_in_reset;
   logic [3:0]       data_clk_vco, lock_pin_in, strap_val, pad_out;
   logic [3:0][7:0]  coarse_tune;
   eye_meas_t        eye_meas [4];
   pin_drive_t [3:0] lock_pin;
   pin_drive_t       int_pin;
   logic [15:0]      rnd;
   logic [31:0]      v;
   int               error_cnt, n_compared, cycle_cnt, exp_status, exp_mask;
   int               cap_q [$];
   refclk_lock_irq i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .reference_clock_input,
      .reference_clock_output, .vco_div_clk, .phase_ok, .eye_meas,
      .eye_valid, .coarse_tune, .cdr_in_reset, .data_clk_vco, .lock_pin_in,
      .lock_pin, .int_pin);
   chan_far_model i_far (.strap_val, .lock_pin, .reference_clock_input,
      .vco_div_clk, .lock_pin_in);
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         pad_out[c] = lock_pin[c].out;
      end
   end
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic apb(input logic [7:0] a, input logic wr,
                      input logic [31:0] d, output logic [31:0] rd_v);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd_v = prdata;
      `CHK("slave error", (a > 8'h24), pslverr)
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_lock(input logic [3:0] want);
      int n;
      n = 0;
      apb(8'h20, 1'b0, 32'h0, v);
      while (v[3:0] !== want && n < 200) begin
         repeat (8) @(posedge pclk);
         apb(8'h20, 1'b0, 32'h0, v);
         n++;
      end
      `CHK("lock status", want, v[3:0])
      `CHK("lock pads", want, pad_out)
   endtask : wait_lock
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   localparam logic [7:0]  RST_A [6] = '{8'h00, 8'h08, 8'h0C, 8'h10,
                                          8'h18, 8'h24};
   localparam logic [31:0] RST_V [6] = '{32'h32, 32'h00FF_3390, 32'h2020,
                                          32'h0, 32'h0, 32'h80};
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, cycle_cnt} = '0;
      {phase_ok, eye_valid, error_cnt, n_compared, exp_status} = '0;
      eye_meas = '{default: '0};
      strap_val = 4'hA;
      rnd = 16'h0B62;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(RST_A[i], 1'b0, 32'h0, v);
         `CHK("reset value", RST_V[i], v)
      end
      apb(8'h3C, 1'b0, 32'h0, v);
      `CHK("unmapped data", 32'h0, v)
      apb(8'h08, 1'b1, 32'h0008_0040, v);
      repeat (30) @(posedge pclk);
      apb(8'h20, 1'b0, 32'h0, v);
      `CHK("straps", 4'hA, v[7:4])
      $display("test reset and straps done");
      phase_ok <= 4'hF;
      wait_lock(4'hF);
      `CHK("retime clock", 4'hF, data_clk_vco)
      phase_ok <= 4'hD;
      repeat (10) @(posedge pclk);
      wait_lock(4'hD);
      apb(8'h14, 1'b0, 32'h0, v);
      `CHK("loss status", 32'h20, v & 32'hF0)
      `CHK("masked loss", 1'b1, int_pin.oe_n)
      phase_ok <= 4'hF;
      wait_lock(4'hF);
      $display("test lock and loss done");
      apb(8'h24, 1'b1, 32'h55, v);
      apb(8'h04, 1'b1, 32'h11, v);
      repeat (4) @(posedge pclk);
      `CHK("cdr reset", 4'h1, cdr_in_reset)
      `CHK("lock in reset", 1'b0, pad_out[0])
      apb(8'h04, 1'b1, 32'h0, v);
      wait_lock(4'hF);
      `CHK("preset tune", 8'h55, coarse_tune[0])
      `CHK("kept tune", 8'h80, coarse_tune[1])
      apb(8'h14, 1'b0, 32'h0, v);
      $display("test cdr reset done");
      apb(8'h00, 1'b1, 32'h30, v);
      apb(8'h00, 1'b0, 32'h0, v);
      `CHK("false lock enable", 32'h30, v)
      repeat (300) @(posedge pclk);
      wait_lock(4'hF);
      apb(8'h10, 1'b1, 32'h7, v);
      exp_mask = 4'hF;
      apb(8'h18, 1'b1, exp_mask, v);
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr_next(rnd);
         if (i == 8) begin
            exp_mask = 4'h0;
            apb(8'h18, 1'b1, exp_mask, v);
         end
         @(posedge pclk);
         eye_meas[rnd[1:0]] <= '{{2'h0, rnd[7:2]}, {2'h0, rnd[13:8]}};
         eye_valid <= 4'h1 << rnd[1:0];
         @(posedge pclk);
         eye_valid <= 4'h0;
         repeat (3) @(posedge pclk);
         if (rnd[1:0] != 2'h3 && (rnd[7:2] < 32 || rnd[13:8] < 32)) begin
            exp_status |= 1 << rnd[1:0];
            if (cap_q.size() == 0) begin
               cap_q.push_back({1'b1, 13'h0, rnd[1:0], 2'h0, rnd[13:8],
                                2'h0, rnd[7:2]});
            end
         end
         `CHK("interrupt", (exp_status & exp_mask) == 0, int_pin.oe_n)
         apb(8'h14, 1'b0, 32'h0, v);
         `CHK("eye status", exp_status, v & 32'hF)
         exp_status = 0;
         apb(8'h1C, 1'b0, 32'h0, v);
         if (cap_q.size() > 0) begin
            `CHK("capture", cap_q.pop_front(), v)
         end else begin
            `CHK("capture valid", 1'b0, v[31])
         end
         repeat (3) @(posedge pclk);
         `CHK("interrupt clear", 1'b1, int_pin.oe_n)
      end
      $display("test eye interrupt done");
      test_done();
   end
endmodule : retimer_refclk_lock_interrupt_tb_top
